// File: pdt_cfg.svh
// Purpose: offsets, field positions, reset values and counts of the timer core
// Assumes: included by its bare name
// Notes: definitions only
`ifndef PDT_CFG_SVH
`define PDT_CFG_SVH

// register regions and words (byte addresses, addr[11:5] picks a region)
`define PDT_CTRL_REGION 7'h00
`define PDT_DATA_REGION 7'h01
`define PDT_MODE_OFF 12'h040
`define PDT_FLAG_OFF 12'h044

// control word fields
`define PDT_RUN_BIT 0
`define PDT_GATE_BIT 1
`define PDT_OSC_BIT 2
`define PDT_DIV_LSB 3
`define PDT_SRC_BIT 6
`define PDT_PRESET_BIT 7

// data word fields
`define PDT_RELOAD_LSB 0
`define PDT_CMP_LSB 8
`define PDT_COUNT_LSB 16

// reset values
`define PDT_RELOAD_RST 8'hff
`define PDT_CMP_RST 8'h00
`define PDT_COUNT_RST 8'hff

// noise rejector width in slow oscillator periods
`define PDT_FILT_SLOW_TICKS 5'h10

// bus answers
`define PDT_RESP_OKAY 2'h0
`define PDT_RESP_SLVERR 2'h2

`endif

// File: pdt_pkg.sv
// Purpose: types shared by the timer core
// Assumes: nothing
// Notes: field layout of the control word lives in pdt_cfg.svh
package pdt_pkg;
	typedef struct packed {
		logic input_source_select;
		logic [2:0] division_ratio_field;
		logic oscillator_source_select;
		logic prescaler_clock_gate;
		logic run_control;
	} pdt_ctrl_t;

	typedef struct packed {
		logic [7:0] compare_match;
		logic [7:0] underflow;
	} pdt_evt_t;
endpackage

// File: pdt_core.sv
// Purpose: eight 8-bit down timers, pairable to 16 bits, with AXI4-Lite registers
// Assumes: both oscillators and the port pins run well below half of ref_clk
// Notes: oscillator and pin edges are sampled, so each count lags by ~3 cycles
// How it works
// - external source counts port pin pulses
// - filter drops pulses under 16 slow periods
// - filter disabled passes pin straight through
// - oscillator select one slow, zero fast
// - fast divisions 1,2,8,32,64,256,1024,4096
// - slow divisions 1,2,4,8,16,32,64,128
// - prescaled clock passes only while gate set
// - paired high half clocked by low underflow
// - reload register readable, writable, resets FFH
// - preset one copies reload into counter
// - paired preset through low; high preset ignored
// - underflow reloads counter from reload value
// - compare register readable, writable, resets 00H
// - compare match when count equals compare
// - run one counts, run zero blocks clock
// - stop and restart keep counter contents
// - paired low run controls both; high ignored
// - counter readable any time, no disturbance
// - events never halt; continue after reload
// - decrement and underflow on pin falling edge; oscillator-sourced counts on oscillator rising edge
// - paired mode flags only on high half
`timescale 1ns/1ps
`include "pdt_cfg.svh"

module pdt_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// oscillators and port pins
	input wire logic slow_oscillator,
	input wire logic fast_oscillator,
	input wire logic [3:0] input_port_pin,
	// one-cycle event pulses
	output pdt_pkg::pdt_evt_t count_event
);
	import pdt_pkg::*;

	pdt_ctrl_t ctrl [0:7];
	logic [7:0] reload_value_reg [0:7];
	logic [7:0] compare_value_reg [0:7];
	logic [7:0][7:0] count_read_buffer;
	logic [3:0] pair_mode;
	logic [3:0] clock_filter_enable;
	logic [7:0] preset_strobe;
	pdt_evt_t flags;
	pdt_evt_t next_event;

	logic [1:0] slow_sync;
	logic [1:0] fast_sync;
	logic slow_d;
	logic fast_d;
	logic slow_tick;
	logic fast_tick;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] external_count_clock;
	logic [7:0] internal_prescaled_clock;
	logic [7:0] timer_tick;

	// axi holding state
	logic aw_full;
	logic w_full;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_write;
	logic wr_ok;
	logic rd_ok;
	logic [31:0] rd_word;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;

	// fast table; slow ratios are plain powers of two
	function automatic logic [11:0] div_limit(input logic slow, input logic [2:0] d);
		logic [11:0] lim;
		lim = 12'h000;
		if (slow) begin
			lim = 12'hfff >> (4'hc - {1'b0, d});
		end else begin
			unique case (d)
				3'h0: lim = 12'h000;
				3'h1: lim = 12'h001;
				3'h2: lim = 12'h007;
				3'h3: lim = 12'h01f;
				3'h4: lim = 12'h03f;
				3'h5: lim = 12'h0ff;
				3'h6: lim = 12'h3ff;
				3'h7: lim = 12'hfff;
			endcase
		end
		return lim;
	endfunction

	// oscillator and pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slow_sync <= 2'h0;
			fast_sync <= 2'h0;
			slow_d <= 1'b0;
			fast_d <= 1'b0;
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end else begin
			slow_sync <= {slow_sync[0], slow_oscillator};
			fast_sync <= {fast_sync[0], fast_oscillator};
			slow_d <= slow_sync[1];
			fast_d <= fast_sync[1];
			pin_s1 <= input_port_pin;
			pin_s2 <= pin_s1;
		end
	end

	assign slow_tick = slow_sync[1] & ~slow_d;
	assign fast_tick = fast_sync[1] & ~fast_d;

	// noise rejector per external input
	generate
		for (genvar i = 0; i < 4; i++) begin : g_in
			logic [4:0] fcnt;
			logic flevel;
			logic lvl_d;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					fcnt <= 5'h00;
					flevel <= 1'b0;
				end else if (!clock_filter_enable[i]) begin
					flevel <= pin_s2[i];
					fcnt <= 5'h00;
				end else if (pin_s2[i] == flevel) begin
					fcnt <= 5'h00;
				end else if (slow_tick) begin
					// level must hold for the full width before it is believed
					if (fcnt == `PDT_FILT_SLOW_TICKS - 5'h01) begin
						flevel <= pin_s2[i];
						fcnt <= 5'h00;
					end else begin
						fcnt <= fcnt + 5'h01;
					end
				end
			end
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					lvl_d <= 1'b0;
				end else begin
					lvl_d <= flevel;
				end
			end
			// counting happens on the falling edge of the input clock
			assign external_count_clock[i] = lvl_d & ~flevel;
		end
	endgenerate

	// prescaler and source selection per timer
	generate
		for (genvar t = 0; t < 8; t++) begin : g_tm
			logic [11:0] pcnt;
			logic [11:0] lim;
			logic src_tick;
			assign lim = div_limit(ctrl[t].oscillator_source_select,
				ctrl[t].division_ratio_field);
			assign src_tick = ctrl[t].oscillator_source_select ? slow_tick : fast_tick;
			always_ff @(posedge ref_clk) begin
				if (rst || !ctrl[t].prescaler_clock_gate) begin
					pcnt <= 12'h000;
				end else if (src_tick) begin
					if (pcnt >= lim) begin
						pcnt <= 12'h000;
					end else begin
						pcnt <= pcnt + 12'h001;
					end
				end
			end
			assign internal_prescaled_clock[t] = ctrl[t].prescaler_clock_gate
				& src_tick & (pcnt >= lim);
			assign timer_tick[t] = ctrl[t].input_source_select
				? external_count_clock[t / 2] : internal_prescaled_clock[t];
		end
	endgenerate

	// counting per pair; even timer is the low half
	generate
		for (genvar p = 0; p < 4; p++) begin : g_pr
			localparam int LO = 2 * p;
			localparam int HI = 2 * p + 1;
			logic [7:0] cnt_lo;
			logic [7:0] cnt_hi;
			logic [15:0] c16;
			logic [15:0] rl16;
			logic [15:0] next_c16;
			logic [7:0] next_lo;
			logic [7:0] next_hi;
			logic tick_lo;
			logic tick_hi;

			assign c16 = {cnt_hi, cnt_lo};
			assign rl16 = {reload_value_reg[HI], reload_value_reg[LO]};
			// zero wraps to the reload value instead of FF
			assign next_c16 = (c16 == 16'h0000) ? rl16 : c16 - 16'h0001;
			assign next_lo = (cnt_lo == 8'h00) ? reload_value_reg[LO] : cnt_lo - 8'h01;
			assign next_hi = (cnt_hi == 8'h00) ? reload_value_reg[HI] : cnt_hi - 8'h01;
			assign tick_lo = timer_tick[LO] & ctrl[LO].run_control;
			assign tick_hi = timer_tick[HI] & ctrl[HI].run_control;

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					cnt_lo <= `PDT_COUNT_RST;
					cnt_hi <= `PDT_COUNT_RST;
				end else if (pair_mode[p]) begin
					// high half follows low underflow; its own clock and run unused
					if (preset_strobe[LO]) begin
						{cnt_hi, cnt_lo} <= rl16;
					end else if (tick_lo) begin
						{cnt_hi, cnt_lo} <= next_c16;
					end
				end else begin
					if (preset_strobe[LO]) begin
						cnt_lo <= reload_value_reg[LO];
					end else if (tick_lo) begin
						cnt_lo <= next_lo;
					end
					// stopped timers simply keep their value
					if (preset_strobe[HI]) begin
						cnt_hi <= reload_value_reg[HI];
					end else if (tick_hi) begin
						cnt_hi <= next_hi;
					end
				end
			end

			always_comb begin
				next_event.underflow[LO] = 1'b0;
				next_event.underflow[HI] = 1'b0;
				next_event.compare_match[LO] = 1'b0;
				next_event.compare_match[HI] = 1'b0;
				if (pair_mode[p]) begin
					if (tick_lo && !preset_strobe[LO]) begin
						next_event.underflow[HI] = (c16 == 16'h0000);
						next_event.compare_match[HI] = (next_c16
							== {compare_value_reg[HI], compare_value_reg[LO]});
					end
				end else begin
					if (tick_lo && !preset_strobe[LO]) begin
						next_event.underflow[LO] = (cnt_lo == 8'h00);
						next_event.compare_match[LO] = (next_lo == compare_value_reg[LO]);
					end
					if (tick_hi && !preset_strobe[HI]) begin
						next_event.underflow[HI] = (cnt_hi == 8'h00);
						next_event.compare_match[HI] = (next_hi == compare_value_reg[HI]);
					end
				end
			end

			assign count_read_buffer[LO] = cnt_lo;
			assign count_read_buffer[HI] = cnt_hi;
		end
	endgenerate

	// event pulses and sticky flags
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_event <= '0;
		end else begin
			count_event <= next_event;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags <= '0;
		end else if (do_write && wr_addr == `PDT_FLAG_OFF) begin
			// a new event beats a clear in the same cycle
			flags.underflow <= (flags.underflow
				& ~(wr_data[7:0] & {8{wr_strb[0]}})) | count_event.underflow;
			flags.compare_match <= (flags.compare_match
				& ~(wr_data[15:8] & {8{wr_strb[1]}})) | count_event.compare_match;
		end else begin
			flags <= flags | count_event;
		end
	end

	// axi write channels, taken in either order
	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_idx = wr_addr[4:2];
	assign wr_ok = (wr_addr[11:5] == `PDT_CTRL_REGION)
		|| (wr_addr[11:5] == `PDT_DATA_REGION)
		|| (wr_addr == `PDT_MODE_OFF) || (wr_addr == `PDT_FLAG_OFF);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_full <= 1'b0;
			wr_addr <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full <= 1'b1;
			wr_addr <= {s_axi_awaddr[11:2], 2'h0};
		end else if (do_write) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			w_full <= 1'b0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PDT_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control, reload and compare registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int k = 0; k < 8; k++) begin
				ctrl[k] <= '0;
				reload_value_reg[k] <= `PDT_RELOAD_RST;
				compare_value_reg[k] <= `PDT_CMP_RST;
			end
		end else if (do_write && wr_addr[11:5] == `PDT_CTRL_REGION && wr_strb[0]) begin
			ctrl[wr_idx].run_control <= wr_data[`PDT_RUN_BIT];
			ctrl[wr_idx].prescaler_clock_gate <= wr_data[`PDT_GATE_BIT];
			ctrl[wr_idx].oscillator_source_select <= wr_data[`PDT_OSC_BIT];
			ctrl[wr_idx].division_ratio_field <= wr_data[`PDT_DIV_LSB +: 3];
			ctrl[wr_idx].input_source_select <= wr_data[`PDT_SRC_BIT];
		end else if (do_write && wr_addr[11:5] == `PDT_DATA_REGION) begin
			// a reload write right after underflow may race the reload
			if (wr_strb[0]) begin
				reload_value_reg[wr_idx] <= wr_data[`PDT_RELOAD_LSB +: 8];
			end
			if (wr_strb[1]) begin
				compare_value_reg[wr_idx] <= wr_data[`PDT_CMP_LSB +: 8];
			end
		end
	end

	// preset is a one-cycle strobe, never stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			preset_strobe <= 8'h00;
		end else begin
			preset_strobe <= 8'h00;
			if (do_write && wr_addr[11:5] == `PDT_CTRL_REGION && wr_strb[0]
				&& wr_data[`PDT_PRESET_BIT]) begin
				preset_strobe[wr_idx] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pair_mode <= 4'h0;
			clock_filter_enable <= 4'h0;
		end else if (do_write && wr_addr == `PDT_MODE_OFF && wr_strb[0]) begin
			pair_mode <= wr_data[3:0];
			clock_filter_enable <= wr_data[7:4];
		end
	end

	// read path
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = s_axi_araddr[4:2];

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr[11:5] == `PDT_CTRL_REGION) begin
			rd_word[`PDT_RUN_BIT] = ctrl[rd_idx].run_control;
			rd_word[`PDT_GATE_BIT] = ctrl[rd_idx].prescaler_clock_gate;
			rd_word[`PDT_OSC_BIT] = ctrl[rd_idx].oscillator_source_select;
			rd_word[`PDT_DIV_LSB +: 3] = ctrl[rd_idx].division_ratio_field;
			rd_word[`PDT_SRC_BIT] = ctrl[rd_idx].input_source_select;
		end else if (s_axi_araddr[11:5] == `PDT_DATA_REGION) begin
			rd_word[`PDT_RELOAD_LSB +: 8] = reload_value_reg[rd_idx];
			rd_word[`PDT_CMP_LSB +: 8] = compare_value_reg[rd_idx];
			rd_word[`PDT_COUNT_LSB +: 8] = count_read_buffer[rd_idx];
		end else if (s_axi_araddr[11:2] == `PDT_MODE_OFF >> 2) begin
			rd_word[7:0] = {clock_filter_enable, pair_mode};
		end else if (s_axi_araddr[11:2] == `PDT_FLAG_OFF >> 2) begin
			rd_word[15:0] = flags;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PDT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: pdt_core_chk.sv
// Purpose: bus and event timing checks for the timer core
// Assumes: sees only the top module ports
// Notes: counter values need register reads, so the bench judges those
`timescale 1ns/1ps
`include "pdt_cfg.svh"

module pdt_core_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// events
	input wire pdt_pkg::pdt_evt_t count_event
);
	import pdt_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	b_code_a: assert property (s_axi_bvalid |->
		s_axi_bresp inside {`PDT_RESP_OKAY, `PDT_RESP_SLVERR}) else $error("bad bresp");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answer pending");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `PDT_RESP_SLVERR |->
		s_axi_rdata == 32'h0) else $error("refused read carries data");
	evt_pulse_a: assert property (count_event != '0 |=>
		(count_event & $past(count_event)) == '0) else $error("event longer than a cycle");
	rst_quiet_a: assert property (disable iff (1'h0) rst |=> count_event == '0 &&
		!s_axi_bvalid && !s_axi_rvalid) else $error("outputs busy in reset");
	idle_start_a: assert property ($fell(rst) |-> (count_event == '0)[*8])
		else $error("event from a stopped timer");
endmodule

bind pdt_core pdt_core_chk chk (.*);

// File: pdt_core_test.sv
// Purpose: self-checking bench for the programmable down timer core
// Assumes: oscillators stepped off ref_clk, fast period 4 cycles, slow 8
// Notes: gaps between event pulses are exact, the first pulse is not
`timescale 1ns/1ps
`include "pdt_cfg.svh"
`define CHK(a, b) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		miscompares++; \
		$display("Error %0t: got %h want %h", $time, (a), (b)); \
	end \
end

module pdt_core_test;
	import pdt_pkg::*;
	localparam logic [1:0] OK = `PDT_RESP_OKAY;
	logic ref_clk = 1'h0, rst = 1'h1, slow_oscillator = 1'h0, fast_oscillator = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0, input_port_pin = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	logic [2:0] ph = 3'h0;
	pdt_evt_t count_event;
	int miscompares = 0, num_checks = 0;
	int fast_div [8] = '{1, 2, 8, 32, 64, 256, 1024, 4096};

	pdt_core uut (.*);

	initial forever #2.5 ref_clk = ~ref_clk;
	// whole-cycle periods keep the measured gaps exact
	always @(posedge ref_clk) begin
		ph <= ph + 3'h1;
		fast_oscillator <= ph[1];
		slow_oscillator <= ph[2];
	end

	task automatic wr(input int a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		bit ad, dd;
		int k;
		ad = 0;
		dd = 0;
		k = 0;
		s_axi_awaddr <= 12'(a);
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(ad && dd) && k < 100) begin
			@(posedge ref_clk);
			k++;
			ad |= s_axi_awready;
			dd |= s_axi_wready;
			if (ad) s_axi_awvalid <= 1'h0;
			if (dd) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_bvalid && ++k < 200);
		if (k >= 200) miscompares++;
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'h0;
	endtask

	task automatic rdr(input int a);
		int k;
		k = 0;
		s_axi_araddr <= 12'(a);
		s_axi_arvalid <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_arready && ++k < 100);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_rvalid && ++k < 200);
		if (k >= 200) miscompares++;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic wait_ev(input int i, output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (!count_event[i] && c < 20000);
		if (c >= 20000) miscompares++;
	endtask

	task automatic t_reset;
		for (int t = 0; t < 8; t++) begin
			rdr(32 + 4 * t);
			`CHK(rd[23:0], 24'hff00ff)
			rdr(4 * t);
			`CHK(rd[7:0], 8'h00)
		end
		rdr(`PDT_MODE_OFF);
		`CHK(rd[7:0], 8'h00)
	endtask

	task automatic t_regs;
		wr(52, 32'hffa5a55a, 4'hf, OK);
		wr(52, 32'h00003c00, 4'h2, OK);
		rdr(52);
		`CHK(rd[23:0], 24'hff3c5a)
		wr(2048, 32'h1, 4'hf, `PDT_RESP_SLVERR);
		rdr(2048);
		`CHK({rs, rd}, {`PDT_RESP_SLVERR, 32'h0})
	endtask

	task automatic t_cmp;
		int c;
		wr(44, 32'h0103, 4'h3, OK);
		wr(12, 32'h83, 4'h1, OK);
		wait_ev(11, c);
		wait_ev(3, c);
		`CHK(c, 8)
		wait_ev(3, c);
		`CHK(c, 16)
		wr(12, 32'h0, 4'h1, OK);
	endtask

	task automatic t_stop;
		logic [7:0] c1;
		wr(48, 32'h40, 4'h1, OK);
		wr(16, 32'h80, 4'h1, OK);
		rdr(48);
		`CHK(rd[23:16], 8'h40)
		wr(16, 32'h3, 4'h1, OK);
		repeat (40) @(posedge ref_clk);
		wr(16, 32'h2, 4'h1, OK);
		rdr(48);
		c1 = rd[23:16];
		`CHK(c1 < 8'h40, 1'h1)
		wr(16, 32'h1, 4'h1, OK);
		repeat (40) @(posedge ref_clk);
		rdr(48);
		`CHK(rd[23:16], c1)
		wr(16, 32'h3, 4'h1, OK);
		repeat (8) @(posedge ref_clk);
		wr(16, 32'h2, 4'h1, OK);
		rdr(48);
		`CHK(rd[23:16] < c1 && rd[23:16] > c1 - 8'h10, 1'h1)
	endtask

	task automatic pulse(input int w, input logic want);
		bit got;
		got = 0;
		input_port_pin <= 4'h8;
		repeat (w) @(posedge ref_clk);
		input_port_pin <= 4'h0;
		repeat (250) begin
			@(posedge ref_clk);
			got |= count_event.underflow[7];
		end
		`CHK(got, want)
	endtask

	task automatic t_pin;
		wr(60, 32'h0, 4'h1, OK);
		wr(28, 32'hc1, 4'h1, OK);
		pulse(3, 1'h1);
		wr(`PDT_MODE_OFF, 32'h80, 4'h1, OK);
		pulse(40, 1'h0);
		pulse(320, 1'h1);
		wr(28, 32'h0, 4'h1, OK);
	endtask

	task automatic t_pair;
		int c;
		logic [7:0] c0;
		wr(`PDT_MODE_OFF, 32'h1, 4'h1, OK);
		wr(32, 32'h1, 4'h1, OK);
		wr(36, 32'h0, 4'h1, OK);
		wr(0, 32'h83, 4'h1, OK);
		wr(`PDT_FLAG_OFF, 32'hffff, 4'h3, OK);
		wait_ev(1, c);
		wait_ev(1, c);
		`CHK(c, 8)
		wr(0, 32'h0, 4'h1, OK);
		rdr(`PDT_FLAG_OFF);
		`CHK({rd[9:8], rd[1:0]}, 4'ha)
		rdr(32);
		c0 = rd[23:16];
		wr(32, 32'h7, 4'h1, OK);
		wr(36, 32'h5, 4'h1, OK);
		wr(4, 32'h87, 4'h1, OK);
		repeat (40) @(posedge ref_clk);
		rdr(32);
		`CHK(rd[23:16], c0)
		// a high preset honoured here would load 05
		rdr(36);
		`CHK(rd[23:16], 8'h00)
		wr(0, 32'h80, 4'h1, OK);
		rdr(32);
		`CHK(rd[23:16], 8'h07)
		rdr(36);
		`CHK(rd[23:16], 8'h05)
		wr(4, 32'h0, 4'h1, OK);
		wr(`PDT_MODE_OFF, 32'h0, 4'h1, OK);
	endtask

	task automatic measure(input int t, input int cw, input int want);
		int c;
		// reload only rewritten while the timer is stopped
		wr(32 + 4 * t, 32'h0, 4'h1, OK);
		wr(4 * t, cw, 4'h1, OK);
		wait_ev(t, c);
		wait_ev(t, c);
		`CHK(c, want)
		wr(4 * t, 32'h0, 4'h1, OK);
	endtask

	task automatic t_rate;
		for (int t = 0; t < 8; t++) begin
			measure(t, 'h83 | t << 3, 4 * fast_div[t]);
			measure(t, 'h87 | t << 3, 8 << t);
		end
	endtask

	task report_and_stop;
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		t_reset;
		t_regs;
		t_cmp;
		t_stop;
		t_pin;
		t_pair;
		t_rate;
		report_and_stop;
	end

	// longest division sweep needs about 50k cycles
	initial begin
		#(120000 * 5);
		miscompares++;
		report_and_stop;
	end
endmodule
